// ===== design/dcx_defs.vh
// Constants for the display controller extended configuration register bank
// Summary of operation
// R1: Start register upper nibble gives cursor bits 19:16, lower nibble start bits 19:16.
// R2: Hardware reset clears every auxiliary control bit.
// R3: Aux bit 7 set gives zero write strobe setup, clear gives half clock.
// R4: Aux bit 6 set gives 4 ns address setup, clear gives half clock.
// R5: Aux bit 5 suppresses vertical sync, bit 0 suppresses horizontal sync.
// R6: Aux bit 4 allows bus memory bursts; clear refuses them.
// R7: Aux bit 3 maps subsystem enable port at 46E8, otherwise 3C3.
// R8: Aux bit 2 floats all listed output pins.
// R9: Aux bit 1 drives clock select line 2 of five.
// R10: Overflow bit 7 enables interlaced odd-then-even line scanning.
// R11: Overflow bit 6 selects secondary controller as vertical interrupt source.
// R12: Overflow bit 5 lets external sync reset counters; tokens show interlace, even field.
// R13: Overflow bits 4:0 are bit 10 of five vertical timing values.
// R14: Overflow bits 3:0 ignore writes while protect bit is set.
// R15: Mapped registers decode only when config bits 5 and 3 both set.
// R16: Config bit 4 enables flat linear video memory map.
// R17: Config bit 3 enables the three aperture buffers.
// R18: Config bits 2:0 give refresh cycles per line; zero means none.
// R19: Config bits 5:3 clear during sequencer synchronous reset.
// R20: Config-2 bit 7 raises low threshold; bit 5 clear raises bandwidth use.
// R21: Config-2 bit 3 selects 9-bit or 10-bit DRAM addresses.
// R22: Config-2 bit 0 selects 32-bit or 16-bit memory data bus.
// R23: Registers other than start and overflow accept writes only with key set.
// R24: Reserved bits ignore writes and read zero.
`ifndef DCX_DEFS_VH
`define DCX_DEFS_VH
`define DCX_IDX_START 8'h33
`define DCX_IDX_AUX 8'h34
`define DCX_IDX_OVF 8'h35
`define DCX_IDX_CFG1 8'h36
`define DCX_IDX_CFG2 8'h37
`define DCX_AUX_RESET 8'h00
`define DCX_START_RESET 8'h00
`define DCX_OVF_RESET 8'h00
`define DCX_CFG1_RESET 8'h00
`define DCX_CFG2_RESET 8'h04
`define DCX_CFG1_MASK 8'h3F
`define DCX_CFG2_MASK 8'hED
`define DCX_OVF_PROT_MASK 8'h0F
`define DCX_CFG1_SYNC_CLR 8'hC7
`define DCX_AUX_WSTRB 7
`define DCX_AUX_ASETUP 6
`define DCX_AUX_VSDIS 5
`define DCX_AUX_BURST 4
`define DCX_AUX_PORTSEL 3
`define DCX_AUX_FLOAT 2
`define DCX_AUX_CS2 1
`define DCX_AUX_HSDIS 0
`define DCX_OVF_ILACE 7
`define DCX_OVF_IRQSEL 6
`define DCX_OVF_GENLOCK 5
`define DCX_CFG1_MMREG 5
`define DCX_CFG1_LINEAR 4
`define DCX_CFG1_APERT 3
`define DCX_CFG2_FIFOLO 7
`define DCX_CFG2_TEST 6
`define DCX_CFG2_FIFOHI 5
`define DCX_CFG2_ADDR9 3
`define DCX_CFG2_LATCH 2
`define DCX_CFG2_BUS32 0
`endif

// ===== design/dcx_ext_regs.v
// Extended configuration register bank of the display timing unit
`timescale 1ns/1ns
`include "dcx_defs.vh"
module dcx_ext_regs (
  input wire clock_in,
  input wire rst_in,
  input wire seq_sync_reset_n_in,
  input wire unlock_key_in,
  input wire timing_protect_in,
  input wire [7:0] index_in,
  input wire wr_en_in,
  input wire [7:0] wr_data_in,
  input wire rd_en_in,
  input wire vert_sync_in,
  input wire horiz_sync_in,
  input wire field_even_in,
  input wire [1:0] token_normal_in,
  output reg [7:0] rd_data_out,
  output reg rd_hit_out,
  output reg [3:0] cursor_addr_hi_out,
  output reg [3:0] start_addr_hi_out,
  output reg mem_write_strobe_zero_setup_out,
  output reg dram_addr_short_setup_out,
  output reg vertical_sync_out,
  output reg horizontal_sync_out,
  output reg burst_enable_out,
  output reg subsystem_enable_port_select_out,
  output reg output_float_control_out,
  output reg video_clock_select_bit2_out,
  output reg interlace_enable_out,
  output reg irq_source_secondary_out,
  output reg external_sync_reset_enable_out,
  output reg [4:0] vert_bit10_out,
  output reg [1:0] token_outputs_out,
  output reg mapped_regs_enable_out,
  output reg linear_map_enable_out,
  output reg aperture_buffer_enable_out,
  output reg [2:0] refresh_count_out,
  output reg refresh_enable_out,
  output reg fifo_low_raise_out,
  output reg fifo_high_normal_out,
  output reg test_mode_out,
  output reg data_latch_normal_out,
  output reg dram_addr_9bit_out,
  output reg mem_bus_32bit_out
);

  reg [7:0] start_q;
  reg [7:0] aux_q;
  reg [7:0] ovf_q;
  reg [7:0] cfg1_q;
  reg [7:0] cfg2_q;
  reg [7:0] ovf_d;
  reg [7:0] rd_d;
  reg hit_d;
  wire wr_start;
  wire wr_aux;
  wire wr_ovf;
  wire wr_cfg1;
  wire wr_cfg2;

  // Index match, used for both write and read decode
  function idx_is;
    input [7:0] idx;
    input [7:0] target;
    begin
      idx_is = (idx == target);
    end
  endfunction

  // Write strobes; keyed registers need the unlock key
  assign wr_start = wr_en_in && idx_is(index_in, `DCX_IDX_START); // see R23
  assign wr_ovf = wr_en_in && idx_is(index_in, `DCX_IDX_OVF); // see R23
  assign wr_aux = wr_en_in && unlock_key_in && idx_is(index_in, `DCX_IDX_AUX); // see R23
  assign wr_cfg1 = wr_en_in && unlock_key_in && idx_is(index_in, `DCX_IDX_CFG1); // see R23
  assign wr_cfg2 = wr_en_in && unlock_key_in && idx_is(index_in, `DCX_IDX_CFG2); // see R23

  // Overflow merge keeping protected timing bits
  always @* begin
    if (timing_protect_in) begin
      ovf_d = (wr_data_in & ~`DCX_OVF_PROT_MASK) | (ovf_q & `DCX_OVF_PROT_MASK); // see R14
    end else begin
      ovf_d = wr_data_in;
    end
  end

  // Register storage
  always @(posedge clock_in) begin
    if (rst_in) begin
      start_q <= `DCX_START_RESET;
      aux_q <= `DCX_AUX_RESET; // see R2
      ovf_q <= `DCX_OVF_RESET;
      cfg1_q <= `DCX_CFG1_RESET;
      cfg2_q <= `DCX_CFG2_RESET;
    end else begin
      if (wr_start) begin
        start_q <= wr_data_in; // see R1
      end
      if (wr_aux) begin
        aux_q <= wr_data_in;
      end
      if (wr_ovf) begin
        ovf_q <= ovf_d;
      end
      if (!seq_sync_reset_n_in) begin
        cfg1_q <= (wr_cfg1 ? (wr_data_in & `DCX_CFG1_MASK) : cfg1_q) & `DCX_CFG1_SYNC_CLR; // see R19
      end else if (wr_cfg1) begin
        cfg1_q <= wr_data_in & `DCX_CFG1_MASK; // see R24
      end
      if (wr_cfg2) begin
        cfg2_q <= wr_data_in & `DCX_CFG2_MASK; // see R24
      end
    end
  end

  // Read mux
  always @* begin
    rd_d = 8'h00;
    hit_d = 1'b1;
    if (idx_is(index_in, `DCX_IDX_START)) begin
      rd_d = start_q;
    end else if (idx_is(index_in, `DCX_IDX_AUX)) begin
      rd_d = aux_q;
    end else if (idx_is(index_in, `DCX_IDX_OVF)) begin
      rd_d = ovf_q;
    end else if (idx_is(index_in, `DCX_IDX_CFG1)) begin
      rd_d = cfg1_q;
    end else if (idx_is(index_in, `DCX_IDX_CFG2)) begin
      rd_d = cfg2_q;
    end else begin
      hit_d = 1'b0;
    end
  end

  // Registered read answer, one cycle after the read enable
  always @(posedge clock_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
      rd_hit_out <= 1'b0;
    end else if (rd_en_in) begin
      rd_data_out <= rd_d;
      rd_hit_out <= hit_d;
    end else begin
      rd_data_out <= 8'h00;
      rd_hit_out <= 1'b0;
    end
  end

  // Control outputs, registered from the register bank and from the sync, field and token inputs
  always @(posedge clock_in) begin
    if (rst_in) begin
      cursor_addr_hi_out <= 4'h0;
      start_addr_hi_out <= 4'h0;
      mem_write_strobe_zero_setup_out <= 1'b0;
      dram_addr_short_setup_out <= 1'b0;
      vertical_sync_out <= 1'b0;
      horizontal_sync_out <= 1'b0;
      burst_enable_out <= 1'b0;
      subsystem_enable_port_select_out <= 1'b0;
      output_float_control_out <= 1'b0;
      video_clock_select_bit2_out <= 1'b0;
      interlace_enable_out <= 1'b0;
      irq_source_secondary_out <= 1'b0;
      external_sync_reset_enable_out <= 1'b0;
      vert_bit10_out <= 5'h00;
      token_outputs_out <= 2'h0;
      mapped_regs_enable_out <= 1'b0;
      linear_map_enable_out <= 1'b0;
      aperture_buffer_enable_out <= 1'b0;
      refresh_count_out <= 3'h0;
      refresh_enable_out <= 1'b0;
      fifo_low_raise_out <= 1'b0;
      fifo_high_normal_out <= 1'b0;
      test_mode_out <= 1'b0;
      data_latch_normal_out <= 1'b1;
      dram_addr_9bit_out <= 1'b0;
      mem_bus_32bit_out <= 1'b0;
    end else begin
      cursor_addr_hi_out <= start_q[7:4]; // see R1
      start_addr_hi_out <= start_q[3:0]; // see R1
      mem_write_strobe_zero_setup_out <= aux_q[`DCX_AUX_WSTRB]; // see R3
      dram_addr_short_setup_out <= aux_q[`DCX_AUX_ASETUP]; // see R4
      vertical_sync_out <= vert_sync_in & ~aux_q[`DCX_AUX_VSDIS]; // see R5
      horizontal_sync_out <= horiz_sync_in & ~aux_q[`DCX_AUX_HSDIS]; // see R5
      burst_enable_out <= aux_q[`DCX_AUX_BURST]; // see R6
      subsystem_enable_port_select_out <= aux_q[`DCX_AUX_PORTSEL]; // see R7
      output_float_control_out <= aux_q[`DCX_AUX_FLOAT]; // see R8
      video_clock_select_bit2_out <= aux_q[`DCX_AUX_CS2]; // see R9
      interlace_enable_out <= ovf_q[`DCX_OVF_ILACE]; // see R10
      irq_source_secondary_out <= ovf_q[`DCX_OVF_IRQSEL]; // see R11
      external_sync_reset_enable_out <= ovf_q[`DCX_OVF_GENLOCK]; // see R12
      vert_bit10_out <= ovf_q[4:0]; // see R13
      // Gen-lock redefines the tokens as interlace and even field
      if (ovf_q[`DCX_OVF_GENLOCK]) begin
        token_outputs_out <= {ovf_q[`DCX_OVF_ILACE], field_even_in}; // see R12
      end else begin
        token_outputs_out <= token_normal_in;
      end
      mapped_regs_enable_out <= cfg1_q[`DCX_CFG1_MMREG] & cfg1_q[`DCX_CFG1_APERT]; // see R15
      linear_map_enable_out <= cfg1_q[`DCX_CFG1_LINEAR]; // see R16
      aperture_buffer_enable_out <= cfg1_q[`DCX_CFG1_APERT]; // see R17
      refresh_count_out <= cfg1_q[2:0]; // see R18
      refresh_enable_out <= |cfg1_q[2:0]; // see R18
      fifo_low_raise_out <= cfg2_q[`DCX_CFG2_FIFOLO]; // see R20
      fifo_high_normal_out <= cfg2_q[`DCX_CFG2_FIFOHI]; // see R20
      test_mode_out <= cfg2_q[`DCX_CFG2_TEST];
      data_latch_normal_out <= cfg2_q[`DCX_CFG2_LATCH];
      dram_addr_9bit_out <= cfg2_q[`DCX_CFG2_ADDR9]; // see R21
      mem_bus_32bit_out <= cfg2_q[`DCX_CFG2_BUS32]; // see R22
    end
  end

endmodule // dcx_ext_regs

// ===== test/dcx_ext_regs_assertions.sv
// Checker for the extended configuration register bank
`timescale 1ns/1ns
module dcx_ext_regs_chk (
  input logic clock_in, rst_in, seq_sync_reset_n_in, unlock_key_in, timing_protect_in, wr_en_in, field_even_in,
  input logic [7:0] index_in, wr_data_in,
  input logic [3:0] cursor_addr_hi_out, start_addr_hi_out,
  input logic vertical_sync_out, horizontal_sync_out, output_float_control_out, interlace_enable_out,
  input logic external_sync_reset_enable_out, linear_map_enable_out, aperture_buffer_enable_out, refresh_enable_out,
  input logic [4:0] vert_bit10_out,
  input logic [1:0] token_outputs_out,
  input logic [2:0] refresh_count_out
);
  logic [15:0] wd_q = 16'h0000;
  wire w34 = wr_en_in && index_in == 8'h34 && unlock_key_in;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Write data two edges back
  always @(posedge clock_in) begin
    wd_q <= {wd_q[7:0], wr_data_in};
  end
  property p_start; wr_en_in && index_in == 8'h33 |=> ##1 {cursor_addr_hi_out, start_addr_hi_out} == wd_q[15:8]; endproperty
  a_start: assert property (p_start) else $error("address nibbles wrong");
  property p_float; w34 |=> ##1 output_float_control_out == wd_q[10]; endproperty
  a_float: assert property (p_float) else $error("float control wrong");
  property p_vs; w34 && wr_data_in[5] |=> ##1 !vertical_sync_out; endproperty
  a_vs: assert property (p_vs) else $error("vertical sync not off");
  property p_hs; w34 && wr_data_in[0] |=> ##1 !horizontal_sync_out; endproperty
  a_hs: assert property (p_hs) else $error("horizontal sync not off");
  property p_key; wr_en_in && index_in == 8'h36 && !unlock_key_in |=> ##1 $stable(refresh_count_out); endproperty
  a_key: assert property (p_key) else $error("locked write took effect");
  property p_prot; wr_en_in && index_in == 8'h35 && timing_protect_in |=> ##1
    $stable(vert_bit10_out[3:0]) && interlace_enable_out == wd_q[15]; endproperty
  a_prot: assert property (p_prot) else $error("protected bits changed");
  property p_sync; !seq_sync_reset_n_in |=> ##1 !(linear_map_enable_out || aperture_buffer_enable_out); endproperty
  a_sync: assert property (p_sync) else $error("config bits not cleared");
  property p_token; external_sync_reset_enable_out |->
    token_outputs_out == {interlace_enable_out, $past(field_even_in)}; endproperty
  a_token: assert property (p_token) else $error("token remap wrong");
  property p_refresh; refresh_enable_out == (refresh_count_out != 3'h0); endproperty
  a_refresh: assert property (p_refresh) else $error("refresh enable wrong");
endmodule // dcx_ext_regs_chk
bind dcx_ext_regs dcx_ext_regs_chk i_dcx_ext_regs_chk (.*);

// ===== test/dcx_timing_model.sv
// Behavioural raster timing source feeding raw syncs and field flag
`timescale 1ns/1ns
module dcx_timing_model (
  input wire clock_in,
  output logic vert_sync_out,
  output logic horiz_sync_out,
  output logic field_even_out
);
  logic [7:0] cnt_q = 8'h00;
  // Short line and frame so sync pulses come often
  always @(posedge clock_in) begin
    cnt_q <= cnt_q + 8'h01;
  end
  assign horiz_sync_out = cnt_q[3:0] == 4'h0;
  assign vert_sync_out = cnt_q[7:5] == 3'h0;
  assign field_even_out = cnt_q[7];
endmodule // dcx_timing_model

// ===== test/tb_dcx_ext_regs.sv
// Self-checking bench for the extended configuration register bank
`timescale 1ns/1ns
module tb_dcx_ext_regs;
  logic clock_in = 0, rst_in = 1, seq_sync_reset_n_in = 1, unlock_key_in = 0, timing_protect_in = 0;
  logic wr_en_in = 0, rd_en_in = 0;
  logic [7:0] index_in = 8'h00, wr_data_in = 8'h00;
  logic [1:0] token_normal_in = 2'h2, seen = 2'h0;
  wire vert_sync_in, horiz_sync_in, field_even_in, rd_hit_out;
  wire [7:0] rd_data_out;
  wire [3:0] cursor_addr_hi_out, start_addr_hi_out;
  wire [4:0] vert_bit10_out;
  wire [1:0] token_outputs_out;
  wire [2:0] refresh_count_out;
  wire mem_write_strobe_zero_setup_out, dram_addr_short_setup_out, vertical_sync_out, horizontal_sync_out;
  wire burst_enable_out, subsystem_enable_port_select_out, output_float_control_out, video_clock_select_bit2_out;
  wire interlace_enable_out, irq_source_secondary_out, external_sync_reset_enable_out, mapped_regs_enable_out;
  wire linear_map_enable_out, aperture_buffer_enable_out, refresh_enable_out, fifo_low_raise_out;
  wire fifo_high_normal_out, test_mode_out, data_latch_normal_out, dram_addr_9bit_out, mem_bus_32bit_out;
  int n_mismatch = 0;
  int tests_run = 0;
  // Rows: index, write data, key, read data, hit
  logic [25:0] rows [6] = '{{8'h33, 8'hA5, 1'b0, 8'hA5, 1'b1}, {8'h34, 8'hFF, 1'b1, 8'hFF, 1'b1},
    {8'h35, 8'hFF, 1'b0, 8'hFF, 1'b1}, {8'h36, 8'hFF, 1'b1, 8'h3F, 1'b1},
    {8'h37, 8'hFF, 1'b1, 8'hED, 1'b1}, {8'h3F, 8'hFF, 1'b1, 8'h00, 1'b0}};
  dcx_timing_model i_dcx_timing_model (.clock_in, .vert_sync_out(vert_sync_in), .horiz_sync_out(horiz_sync_in),
    .field_even_out(field_even_in));
  dcx_ext_regs i_dcx_ext_regs (.*);
  initial begin
    forever #50 clock_in = ~clock_in;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic k);
    @(posedge clock_in) {index_in, wr_data_in, unlock_key_in, wr_en_in} <= {i, d, k, 1'b1};
    @(posedge clock_in) wr_en_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic h);
    @(posedge clock_in) {index_in, rd_en_in} <= {i, 1'b1};
    @(posedge clock_in) rd_en_in <= 1'b0;
    #1 chk({rd_hit_out, rd_data_out}, {h, e});
  endtask
  // Collect any sync pulse seen over a full model frame, sampled after the edge settles
  task automatic watch_syncs;
    seen = 2'h0;
    repeat (256) begin
      @(posedge clock_in);
      #1 seen |= {vertical_sync_out, horizontal_sync_out};
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog against a hung run
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i][25:18], rows[i][17:10], rows[i][9]);
      rd(rows[i][25:18], rows[i][8:1], rows[i][0]);
    end
    chk({cursor_addr_hi_out, start_addr_hi_out}, 8'hA5);
    chk({mem_write_strobe_zero_setup_out, dram_addr_short_setup_out, burst_enable_out,
      subsystem_enable_port_select_out, output_float_control_out, video_clock_select_bit2_out}, 6'h3F);
    chk({vertical_sync_out, horizontal_sync_out, token_outputs_out[1]}, 3'h1);
    watch_syncs;
    chk(seen, 2'h0);
    chk({interlace_enable_out, irq_source_secondary_out, external_sync_reset_enable_out, vert_bit10_out}, 8'hFF);
    chk({mapped_regs_enable_out, linear_map_enable_out, aperture_buffer_enable_out, refresh_count_out}, 6'h3F);
    chk({fifo_low_raise_out, test_mode_out, fifo_high_normal_out, dram_addr_9bit_out, data_latch_normal_out,
      mem_bus_32bit_out}, 6'h3F);
    $display("test rows done");
    @(posedge clock_in) rst_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 5; i++) rd(8'h33 + i[7:0], (i == 4) ? 8'h04 : 8'h00, 1'b1);
    chk({token_outputs_out, data_latch_normal_out, output_float_control_out}, 4'hA);
    $display("test reset done");
    wr(8'h34, 8'hFF, 1'b1);
    wr(8'h34, 8'h00, 1'b0);
    rd(8'h34, 8'hFF, 1'b1);
    wr(8'h34, 8'h00, 1'b1);
    watch_syncs;
    chk(seen, 2'h3);
    wr(8'h35, 8'hFF, 1'b0);
    @(posedge clock_in) timing_protect_in <= 1'b1;
    wr(8'h35, 8'h00, 1'b0);
    rd(8'h35, 8'h0F, 1'b1);
    wr(8'h36, 8'h27, 1'b1);
    @(posedge clock_in);
    #1 chk({mapped_regs_enable_out, linear_map_enable_out, aperture_buffer_enable_out,
      refresh_count_out}, 6'h07);
    wr(8'h36, 8'h3F, 1'b1);
    @(posedge clock_in) seq_sync_reset_n_in <= 1'b0;
    wr(8'h36, 8'h3A, 1'b1);
    rd(8'h36, 8'h02, 1'b1);
    wr(8'h36, 8'h00, 1'b1);
    wr(8'h36, 8'h05, 1'b0);
    repeat (2) @(posedge clock_in);
    #1 chk({refresh_enable_out, refresh_count_out}, 4'h0);
    $display("test refusals done");
    tally_and_finish;
  end
endmodule // tb_dcx_ext_regs
